// File: design/adm_mode_controller.sv
// Operating mode controller of the analog companion die: power down, reset, normal,
// stop and sleep sequencing, reset pin control, reset causes and wake handling.
// Assumes register accesses from the die link arrive as single-cycle strobes on clk_sys
// and that supply comparators and wake sources are already synchronous.
`timescale 1ns/100ps

// Notes on behaviour
// - Exactly one of Power Down, Reset, Normal, Stop, Sleep is held.
// - Sleep turns both core and I/O regulators off.
// - A wake that ends Stop raises the wake interrupt to the microcontroller.
// - A wake that ends Sleep enters Reset with regulators back on.
// - Main supply below threshold holds Power Down; rising enters Reset, power-on cause.
// - Reset entered on power-on, core LV, I/O LV, watchdog, external, sleep wake.
// - Internal causes hold reset pin low for the hold time after they end.
// - Reset exits to Normal only with pin high and both LV detectors inactive.
// - Supply low in Reset beyond short-circuit timeout with main supply high goes to Sleep.
// - One reset-cause flag per cause shows what produced the last reset.
// - Normal starts watchdog non-window with initial timeout; first service enables window.
// - Stop keeps regulators on at reduced drive and the die link working.
// - After a wake, a new Stop request acts only after wake sources are read.
// - Local, forced, LIN or die-link wake moves Stop to Normal.
// - A reset condition during Stop goes straight to Reset.
// - Sleep wakes on local, forced or LIN only, to Reset; die link off.
// - Mode field write requests: 01 Stop, 10 Sleep, 11 Normal.
// - Mode field 00 acts only in Stop, forcing wake to Normal.
// - Registers sit at offsets from 0x200 blocking and 0x300 non-blocking.
module adm_mode_controller #(
  parameter int N_LOCAL_WAKE     = 6,
  parameter int RST_HOLD_CYCLES  = adm_pkg::RST_HOLD_CYCLES,
  parameter int SC_TIMEOUT_CYCLES = adm_pkg::SC_TIMEOUT_CYCLES,
  parameter int INIT_WDOG_CYCLES = adm_pkg::INIT_WDOG_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire logic [9:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rd_valid,
  input  wire logic                    main_supply_ok,
  input  wire logic                    main_supply_high,
  input  wire logic                    core_low_voltage,
  input  wire logic                    io_low_voltage,
  input  wire logic [N_LOCAL_WAKE-1:0] local_wake_inputs,
  input  wire logic                    forced_wake,
  input  wire logic                    lin_wake,
  input  wire logic                    die_link_wake,
  input  wire logic                    wdog_service,
  input  wire logic                    wdog_fault,
  input  wire logic                    reset_pin_in,
  output logic                         reset_pin_out,
  output logic                         reset_pin_oe,
  output logic                         core_reg_en,
  output logic                         io_reg_en,
  output logic                         reg_low_drive,
  output logic                         die_link_en,
  output logic                         wake_irq,
  output logic                         wdog_enable,
  output logic                         wdog_window_mode,
  output logic      [2:0]              op_mode
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (N_LOCAL_WAKE < 1 || N_LOCAL_WAKE > 6) begin : g_bad_wake
    $error("adm_mode_controller: N_LOCAL_WAKE must be 1 to 6");
  end
  if (RST_HOLD_CYCLES < 1 || SC_TIMEOUT_CYCLES < 1 || INIT_WDOG_CYCLES < 1) begin : g_bad_time
    $error("adm_mode_controller: timing counts must be at least one cycle");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  adm_pkg::adm_state_e state;
  adm_pkg::adm_state_e next_state;

  logic [1:0]                   mode_field;
  logic                         pending_stop;
  logic                         pending_sleep;
  logic                         stop_armed;
  logic [7:0]                   wake_flags;
  logic [adm_pkg::CAUSE_NUM-1:0] reset_cause;
  logic [adm_pkg::CAUSE_NUM-1:0] causes_now;
  logic                         drove_pin;

  logic       base_hit;
  logic [7:0] offs;
  logic       mode_wr;
  logic       wake_rd;
  logic       ext_low;
  logic       any_lv;
  logic       stop_wake;
  logic       sleep_wake;
  logic       go_reset;
  logic       hold_load;
  logic       hold_done;
  logic       sc_cond;
  logic       sc_zero;
  logic       sc_fire;
  logic       wdog_init_load;
  logic       wdog_init_zero;
  logic       wdog_init_fire;
  logic       exit_reset;
  logic [7:0] next_wake_set;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Both windows reach the same registers; the access style only matters to the link.
  assign base_hit = (reg_addr[9:8] == adm_pkg::BASE_BLOCKING[9:8]) ||
                    (reg_addr[9:8] == adm_pkg::BASE_NONBLOCKING[9:8]);
  assign offs     = reg_addr[7:0];
  assign mode_wr  = reg_wr_en && base_hit && (offs == adm_pkg::OFFS_MODE_CTRL);
  assign wake_rd  = reg_rd_en && base_hit && (offs == adm_pkg::OFFS_WAKE_SOURCE);

  // ****************************************************************
  // Condition decode
  // ****************************************************************
  // The pin still reads low for a cycle after our own release; drove_pin masks that.
  assign ext_low = !reset_pin_in && !reset_pin_oe && !drove_pin;
  assign any_lv  = core_low_voltage || io_low_voltage;

  assign stop_wake = (state == adm_pkg::ADM_ST_STOP) &&
                     ((|local_wake_inputs) || forced_wake || lin_wake || die_link_wake ||
                      (mode_wr && reg_wdata[1:0] == adm_pkg::MSEL_WAKE));
  // The die link is down in Sleep, so its wake is not looked at there.
  assign sleep_wake = (state == adm_pkg::ADM_ST_SLEEP) &&
                      ((|local_wake_inputs) || forced_wake || lin_wake);

  // Low-voltage causes are recorded only when they knock a running die into Reset;
  // inside Reset they are expected during ramp-up; they block the exit, restart the hold and feed the short-circuit timeout.
  always_comb begin
    causes_now = '0;
    causes_now[adm_pkg::CAUSE_POR]  = (state == adm_pkg::ADM_ST_POWER_DOWN) &&
                                      main_supply_ok;
    causes_now[adm_pkg::CAUSE_CORE] = core_low_voltage &&
                                      (state == adm_pkg::ADM_ST_NORMAL ||
                                       state == adm_pkg::ADM_ST_STOP);
    causes_now[adm_pkg::CAUSE_IO]   = io_low_voltage &&
                                      (state == adm_pkg::ADM_ST_NORMAL ||
                                       state == adm_pkg::ADM_ST_STOP);
    causes_now[adm_pkg::CAUSE_WDOG] = (state == adm_pkg::ADM_ST_NORMAL) &&
                                      (wdog_fault || wdog_init_fire);
    causes_now[adm_pkg::CAUSE_EXT]  = ext_low &&
                                      (state == adm_pkg::ADM_ST_NORMAL ||
                                       state == adm_pkg::ADM_ST_STOP ||
                                       state == adm_pkg::ADM_ST_RESET);
    causes_now[adm_pkg::CAUSE_WAKE] = sleep_wake;
  end

  assign go_reset = |causes_now;

  // ****************************************************************
  // Timers
  // ****************************************************************
  // Any internal cause, or a low supply while in Reset, restarts the hold.
  assign hold_load = (|(causes_now & ~(adm_pkg::CAUSE_NUM'(1) << adm_pkg::CAUSE_EXT))) ||
                     (state == adm_pkg::ADM_ST_POWER_DOWN) ||
                     (state == adm_pkg::ADM_ST_RESET && any_lv);

  adm_down_timer #(
    .WIDTH (32)
  ) u_hold_timer (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .load       (hold_load),
    .run        (1'b1),
    .load_value (32'(RST_HOLD_CYCLES)),
    .expired    (hold_done)
  );

  assign sc_cond = (state == adm_pkg::ADM_ST_RESET) && any_lv && main_supply_high;
  assign sc_fire = sc_cond && sc_zero;

  adm_down_timer #(
    .WIDTH (32)
  ) u_sc_timer (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .load       (!sc_cond),
    .run        (sc_cond),
    .load_value (32'(SC_TIMEOUT_CYCLES)),
    .expired    (sc_zero)
  );

  assign wdog_init_load = (state != adm_pkg::ADM_ST_NORMAL) || wdog_window_mode;
  assign wdog_init_fire = (state == adm_pkg::ADM_ST_NORMAL) && !wdog_window_mode &&
                          wdog_init_zero;

  adm_down_timer #(
    .WIDTH (32)
  ) u_wdog_init_timer (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .load       (wdog_init_load),
    .run        (1'b1),
    .load_value (32'(INIT_WDOG_CYCLES)),
    .expired    (wdog_init_zero)
  );

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  assign exit_reset = reset_pin_in && !reset_pin_oe && !drove_pin && !any_lv &&
                      !hold_load && hold_done;

  always_comb begin
    next_state = state;
    if (!main_supply_ok) begin
      next_state = adm_pkg::ADM_ST_POWER_DOWN;
    end else begin
      case (state)
        adm_pkg::ADM_ST_POWER_DOWN: begin
          next_state = adm_pkg::ADM_ST_RESET;
        end
        adm_pkg::ADM_ST_RESET: begin
          if (sc_fire) begin
            next_state = adm_pkg::ADM_ST_SLEEP;
          end else if (exit_reset) begin
            next_state = adm_pkg::ADM_ST_NORMAL;
          end
        end
        adm_pkg::ADM_ST_NORMAL: begin
          if (go_reset) begin
            next_state = adm_pkg::ADM_ST_RESET;
          end else if (pending_sleep) begin
            next_state = adm_pkg::ADM_ST_SLEEP;
          end else if (pending_stop && stop_armed) begin
            next_state = adm_pkg::ADM_ST_STOP;
          end
        end
        adm_pkg::ADM_ST_STOP: begin
          if (go_reset) begin
            next_state = adm_pkg::ADM_ST_RESET;
          end else if (stop_wake) begin
            next_state = adm_pkg::ADM_ST_NORMAL;
          end
        end
        adm_pkg::ADM_ST_SLEEP: begin
          if (go_reset) begin
            next_state = adm_pkg::ADM_ST_RESET;
          end
        end
        default: begin
          next_state = adm_pkg::ADM_ST_POWER_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= adm_pkg::ADM_ST_POWER_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Mode control register and pending requests
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_field    <= adm_pkg::MODE_CTRL_RESET;
      pending_stop  <= 1'b0;
      pending_sleep <= 1'b0;
    end else if (next_state == adm_pkg::ADM_ST_RESET ||
                 next_state == adm_pkg::ADM_ST_POWER_DOWN) begin
      mode_field    <= adm_pkg::MODE_CTRL_RESET;
      pending_stop  <= 1'b0;
      pending_sleep <= 1'b0;
    end else begin
      if (mode_wr) begin
        mode_field <= reg_wdata[1:0];
      end
      if (next_state != state) begin
        pending_stop  <= 1'b0;
        pending_sleep <= 1'b0;
      end else if (mode_wr) begin
        // A Stop request waits here until the wake sources have been read.
        pending_stop  <= (reg_wdata[1:0] == adm_pkg::MSEL_STOP);
        pending_sleep <= (reg_wdata[1:0] == adm_pkg::MSEL_SLEEP);
      end
    end
  end

  // ****************************************************************
  // Wake sources, stop arming and wake interrupt
  // ****************************************************************
  always_comb begin
    next_wake_set = '0;
    if (state == adm_pkg::ADM_ST_STOP || state == adm_pkg::ADM_ST_SLEEP) begin
      next_wake_set[N_LOCAL_WAKE-1:0]        = local_wake_inputs;
      next_wake_set[adm_pkg::WAKE_BIT_FORCED] = forced_wake;
      next_wake_set[adm_pkg::WAKE_BIT_LIN]    = lin_wake;
    end
  end

  // New wake events win over the clear caused by a read in the same cycle.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_flags <= adm_pkg::WAKE_SRC_RESET;
    end else if (wake_rd) begin
      wake_flags <= next_wake_set;
    end else begin
      wake_flags <= wake_flags | next_wake_set;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stop_armed <= 1'b1;
    end else if (stop_wake || sleep_wake) begin
      stop_armed <= 1'b0;
    end else if (wake_rd) begin
      stop_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_irq <= 1'b0;
    end else if (stop_wake && next_state == adm_pkg::ADM_ST_NORMAL) begin
      wake_irq <= 1'b1;
    end else if (wake_rd || next_state != adm_pkg::ADM_ST_NORMAL) begin
      wake_irq <= 1'b0;
    end
  end

  // ****************************************************************
  // Reset causes
  // ****************************************************************
  // Entry into Reset replaces the record; causes arriving during Reset add to it.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_cause <= adm_pkg::CAUSE_RESET;
    end else if (state != adm_pkg::ADM_ST_RESET && next_state == adm_pkg::ADM_ST_RESET) begin
      reset_cause <= causes_now;
    end else if (state == adm_pkg::ADM_ST_RESET) begin
      reset_cause <= reset_cause | causes_now;
    end
  end

  // ****************************************************************
  // Reset pin
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_pin_oe  <= 1'b1;
      reset_pin_out <= 1'b0;
      drove_pin     <= 1'b1;
    end else begin
      reset_pin_oe  <= (next_state == adm_pkg::ADM_ST_POWER_DOWN) ||
                       (next_state == adm_pkg::ADM_ST_RESET && (hold_load || !hold_done));
      reset_pin_out <= 1'b0;
      drove_pin     <= reset_pin_oe;
    end
  end

  // ****************************************************************
  // Regulator, link and watchdog controls
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      core_reg_en   <= 1'b0;
      io_reg_en     <= 1'b0;
      reg_low_drive <= 1'b0;
      die_link_en   <= 1'b0;
      op_mode       <= adm_pkg::OPM_POWER_DOWN;
    end else begin
      core_reg_en   <= (next_state != adm_pkg::ADM_ST_SLEEP) &&
                       (next_state != adm_pkg::ADM_ST_POWER_DOWN);
      io_reg_en     <= (next_state != adm_pkg::ADM_ST_SLEEP) &&
                       (next_state != adm_pkg::ADM_ST_POWER_DOWN);
      reg_low_drive <= (next_state == adm_pkg::ADM_ST_STOP);
      die_link_en   <= (next_state == adm_pkg::ADM_ST_NORMAL) ||
                       (next_state == adm_pkg::ADM_ST_STOP);
      case (next_state)
        adm_pkg::ADM_ST_RESET:  op_mode <= adm_pkg::OPM_RESET;
        adm_pkg::ADM_ST_NORMAL: op_mode <= adm_pkg::OPM_NORMAL;
        adm_pkg::ADM_ST_STOP:   op_mode <= adm_pkg::OPM_STOP;
        adm_pkg::ADM_ST_SLEEP:  op_mode <= adm_pkg::OPM_SLEEP;
        default:                op_mode <= adm_pkg::OPM_POWER_DOWN;
      endcase
    end
  end

  // Every entry into Normal restarts the watchdog in its initial non-window phase.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wdog_enable      <= 1'b0;
      wdog_window_mode <= 1'b0;
    end else begin
      wdog_enable <= (next_state == adm_pkg::ADM_ST_NORMAL);
      if (next_state != adm_pkg::ADM_ST_NORMAL || state != adm_pkg::ADM_ST_NORMAL) begin
        wdog_window_mode <= 1'b0;
      end else if (wdog_service) begin
        wdog_window_mode <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en && base_hit) begin
        case (offs)
          adm_pkg::OFFS_MODE_CTRL:   reg_rdata <= {6'h00, mode_field};
          adm_pkg::OFFS_WAKE_SOURCE: reg_rdata <= wake_flags;
          adm_pkg::OFFS_RESET_CAUSE: reg_rdata <= {2'h0, reset_cause};
          default:                   reg_rdata <= 8'h00;
        endcase
      end else if (reg_rd_en) begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule : adm_mode_controller

// File: shared/adm_pkg.sv
// Shared constants of the analog die mode controller: register map, field layout,
// reset values, reset-cause bit order and timing figures.
// Assumes a 250 MHz system clock; all times are converted to cycles from CLK_PERIOD_NS.
package adm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [9:0] BASE_BLOCKING    = 10'h200;
  localparam logic [9:0] BASE_NONBLOCKING = 10'h300;
  localparam logic [7:0] OFFS_WAKE_SOURCE = 8'h14;
  localparam logic [7:0] OFFS_MODE_CTRL   = 8'h16;
  localparam logic [7:0] OFFS_RESET_CAUSE = 8'h17;

  localparam logic [1:0] MODE_CTRL_RESET  = 2'h0;
  localparam logic [7:0] WAKE_SRC_RESET   = 8'h00;
  localparam logic [5:0] CAUSE_RESET      = 6'h00;

  // Wake source layout: local inputs in the low bits.
  localparam int WAKE_BIT_FORCED = 7;
  localparam int WAKE_BIT_LIN    = 6;

  // Mode select encodings.
  localparam logic [1:0] MSEL_WAKE   = 2'h0;
  localparam logic [1:0] MSEL_STOP   = 2'h1;
  localparam logic [1:0] MSEL_SLEEP  = 2'h2;
  localparam logic [1:0] MSEL_NORMAL = 2'h3;

  // Reset cause bit positions.
  localparam int CAUSE_POR  = 0;
  localparam int CAUSE_CORE = 1;
  localparam int CAUSE_IO   = 2;
  localparam int CAUSE_WDOG = 3;
  localparam int CAUSE_EXT  = 4;
  localparam int CAUSE_WAKE = 5;
  localparam int CAUSE_NUM  = 6;

  // Operating mode codes shown on the status output.
  localparam logic [2:0] OPM_POWER_DOWN = 3'h0;
  localparam logic [2:0] OPM_RESET      = 3'h1;
  localparam logic [2:0] OPM_NORMAL     = 3'h2;
  localparam logic [2:0] OPM_STOP       = 3'h3;
  localparam logic [2:0] OPM_SLEEP      = 3'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 4;
  localparam int RST_HOLD_NS      = 20000;
  localparam int SC_TIMEOUT_NS    = 100000;
  localparam int INIT_WDOG_TO_NS  = 1000000;
  // Least times round up, the longest time rounds down.
  localparam int RST_HOLD_CYCLES  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_TIMEOUT_CYCLES = (SC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_WDOG_CYCLES = INIT_WDOG_TO_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ADM_ST_POWER_DOWN,
    ADM_ST_RESET,
    ADM_ST_NORMAL,
    ADM_ST_STOP,
    ADM_ST_SLEEP
  } adm_state_e;

endpackage : adm_pkg

// File: design/adm_down_timer.sv
// Loadable down counter used for the reset hold, the short-circuit timeout and
// the initial watchdog timeout.
// Assumes the load value is stable while counting.
`timescale 1ns/100ps
module adm_down_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired
);

  logic [WIDTH-1:0] count;

  if (WIDTH < 2) begin : g_bad_width
    $error("adm_down_timer: WIDTH must be at least 2");
  end

  // Load has priority so a condition that persists keeps the timer from expiring.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (run && count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  assign expired = (count == '0);

endmodule : adm_down_timer

// File: testbench/adm_properties.sv
// Port properties of the mode controller, bound to its top module.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module adm_properties (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       main_supply_ok,
  input wire logic       core_low_voltage,
  input wire logic       io_low_voltage,
  input wire logic       wdog_fault,
  input wire logic       reset_pin_in,
  input wire logic       reset_pin_oe,
  input wire logic       core_reg_en,
  input wire logic       io_reg_en,
  input wire logic       reg_low_drive,
  input wire logic       die_link_en,
  input wire logic       wdog_enable,
  input wire logic [2:0] op_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_exit; op_mode == 3'h1 ##1 op_mode == 3'h2; endsequence
  property p_code; op_mode <= 3'h4; endproperty
  a_code: assert property (p_code) else $error("bad mode");
  property p_sleep; op_mode == 3'h4 |-> !core_reg_en && !io_reg_en; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep regs");
  property p_stop; op_mode == 3'h3 |-> core_reg_en && io_reg_en && reg_low_drive && die_link_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop outputs");
  property p_pwr; op_mode == 3'h0 && main_supply_ok |=> op_mode == 3'h1; endproperty
  a_pwr: assert property (p_pwr) else $error("power up");
  property p_exit;
    s_exit |-> $past(reset_pin_in) && !$past(core_low_voltage) && !$past(io_low_voltage);
  endproperty
  a_exit: assert property (p_exit) else $error("reset exit");
  property p_slpx; op_mode == 3'h4 |=> op_mode inside {3'h0, 3'h1, 3'h4}; endproperty
  a_slpx: assert property (p_slpx) else $error("sleep exit");
  property p_hold; op_mode == 3'h2 && wdog_fault |=> reset_pin_oe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("pin hold");
  property p_wd; wdog_enable == (op_mode == 3'h2); endproperty
  a_wd: assert property (p_wd) else $error("watchdog run");
endmodule : adm_properties
bind adm_mode_controller adm_properties u_props (.*);

// File: testbench/adm_mcu_model.sv
// Microcontroller side of the die link: single register accesses.
// Assumes calls come from one process only.
`timescale 1ns/100ps
module adm_mcu_model (
  input wire logic clk_sys,
  output logic       wr_en,
  output logic       rd_en,
  output logic [9:0] addr,
  output logic [7:0] wdata
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
    @(negedge clk_sys);
    {wr_en, rd_en, addr, wdata} = {2'h0, ~a, ~d};
    if (!w && a[7:0] == adm_pkg::OFFS_WAKE_SOURCE) repeat (2) @(negedge clk_sys);
  endtask : acc
endmodule : adm_mcu_model

// File: testbench/analog_die_mode_controller_test.sv
// Self-checking bench of the mode controller; counts are shortened.
`timescale 1ns/100ps
module analog_die_mode_controller_test;
  logic clk_sys = 0, sys_rst = 1, ok = 0, clv = 0, iolv = 0, fw = 0, lw = 0, dw = 0, svc = 0;
  logic wf = 0, ext_n = 1, we, re, rv, oe, po, ce, ie, ld, de, wi, wen, wwm;
  logic [5:0] lx = 0;
  logic [9:0] a;
  logic [7:0] wd, rdat;
  logic [2:0] op_mode;
  int   n_mismatch = 0, check_count = 0, k, b, pk, pb;
  wire  pin = ~oe & ext_n;
  always #2 clk_sys = ~clk_sys;
  adm_mcu_model u_mcu (.clk_sys(clk_sys), .wr_en(we), .rd_en(re), .addr(a), .wdata(wd));
  adm_mode_controller #(.RST_HOLD_CYCLES(20), .SC_TIMEOUT_CYCLES(50), .INIT_WDOG_CYCLES(2000))
    u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(we), .reg_rd_en(re), .reg_addr(a),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_rd_valid(rv), .main_supply_ok(ok),
    .main_supply_high(ok), .core_low_voltage(clv), .io_low_voltage(iolv), .wdog_fault(wf),
    .local_wake_inputs(lx), .forced_wake(fw), .lin_wake(lw), .die_link_wake(dw),
    .wdog_service(svc), .reset_pin_in(pin), .reset_pin_out(po), .reset_pin_oe(oe),
    .core_reg_en(ce), .io_reg_en(ie), .reg_low_drive(ld), .die_link_en(de), .wake_irq(wi),
    .wdog_enable(wen), .wdog_window_mode(wwm), .op_mode(op_mode));
  task automatic chk(input string n, input logic [7:0] e, s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Servicing on every Normal entry keeps the initial watchdog from firing.
  task automatic wt(input logic [2:0] m);
    for (int i = 0; i < 300 && op_mode !== m; i++) @(negedge clk_sys);
    chk("op_mode", {5'h0, m}, {5'h0, op_mode});
    svc = (m == adm_pkg::OPM_NORMAL);
    @(negedge clk_sys);
    svc = 0;
  endtask : wt
  task automatic rd(input logic [7:0] o, e);
    u_mcu.acc(1'b0, {2'h2, o}, 8'h00);
    chk("rdata", e, rdat);
  endtask : rd
  task automatic wm(input logic [1:0] v);
    u_mcu.acc(1'b1, {2'h3, adm_pkg::OFFS_MODE_CTRL}, {6'h0, v});
  endtask : wm
  task automatic wake(input int w, input int i);
    case (w)
      0: lx[i] = 1;
      1: fw = 1;
      2: lw = 1;
      3: dw = 1;
      default: wm(adm_pkg::MSEL_WAKE);
    endcase
    @(negedge clk_sys);
    {lx, fw, lw, dw} = '0;
  endtask : wake
  function automatic logic [7:0] exp_wsr(input int w, input int i);
    case (w)
      0: return 8'h01 << i;
      1: return 8'h01 << adm_pkg::WAKE_BIT_FORCED;
      2: return 8'h01 << adm_pkg::WAKE_BIT_LIN;
      default: return 8'h00;
    endcase
  endfunction : exp_wsr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h8223D0F2));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 0;
    repeat (4) @(negedge clk_sys);
    chk("op_mode", 8'h00, {5'h0, op_mode});
    ok = 1;
    wt(adm_pkg::OPM_RESET);
    rd(adm_pkg::OFFS_RESET_CAUSE, 8'h01);
    for (int i = 0; i < 300 && op_mode !== 3'h2; i++) @(negedge clk_sys);
    chk("window", 8'h00, {7'h0, wwm});
    wt(adm_pkg::OPM_NORMAL);
    chk("window", 8'h01, {7'h0, wwm});
    wm(adm_pkg::MSEL_WAKE);
    wm(adm_pkg::MSEL_NORMAL);
    rd(adm_pkg::OFFS_MODE_CTRL, 8'h03);
    rd(8'hFF, 8'h00);
    wt(adm_pkg::OPM_NORMAL);
    for (int i = 0; i < 8; i++) begin
      k = (i < 5) ? i : $urandom_range(4);
      b = $urandom_range(5);
      wm(adm_pkg::MSEL_STOP);
      if (i > 0) begin
        repeat (3) @(negedge clk_sys);
        chk("op_mode", 8'h02, {5'h0, op_mode});
        rd(adm_pkg::OFFS_WAKE_SOURCE, exp_wsr(pk, pb));
      end
      wt(adm_pkg::OPM_STOP);
      wake(k, b);
      wt(adm_pkg::OPM_NORMAL);
      chk("wake_irq", 8'h01, {7'h0, wi});
      pk = k;
      pb = b;
    end
    wm(adm_pkg::MSEL_SLEEP);
    wt(adm_pkg::OPM_SLEEP);
    wake(3, 0);
    wt(adm_pkg::OPM_SLEEP);
    wake(2, 0);
    wt(adm_pkg::OPM_RESET);
    chk("reg_en", 8'h03, {6'h0, ce, ie});
    chk("pin_out", 8'h00, {7'h0, po});
    rd(adm_pkg::OFFS_MODE_CTRL, 8'h00);
    rd(adm_pkg::OFFS_RESET_CAUSE, 8'h01 << adm_pkg::CAUSE_WAKE);
    for (int c = 1; c < 5; c++) begin
      wt(adm_pkg::OPM_NORMAL);
      {clv, iolv, wf, ext_n} = 4'h1 ^ (5'h10 >> c);
      @(negedge clk_sys);
      {clv, iolv, wf, ext_n} = 4'h1;
      wt(adm_pkg::OPM_RESET);
      rd(adm_pkg::OFFS_RESET_CAUSE, 8'h01 << c);
    end
    iolv = 1;
    wt(adm_pkg::OPM_SLEEP);
    wrap_up;
  end
endmodule : analog_die_mode_controller_test
